/* File: hw/emacr_regs.vh */
// Purpose: register offsets, fields and reset values of the receive status
//          and flow control block
// Assumes: 8-bit register port, byte offsets
// Notes:   definitions only
`ifndef EMACR_REGS_VH
`define EMACR_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define EMACR_OFS_CFG1      8'h20
`define EMACR_OFS_GAP       8'h2F
`define EMACR_OFS_MAXLEN_L  8'h30
`define EMACR_OFS_MAXLEN_H  8'h31
`define EMACR_OFS_RRP_L     8'h49
`define EMACR_OFS_RRP_H     8'h4A
`define EMACR_OFS_THRESH    8'h4C
`define EMACR_OFS_ISTAT     8'h60
`define EMACR_OFS_IMASK     8'h61
`define EMACR_OFS_RXST_L    8'h62
`define EMACR_OFS_RXST_H    8'h63

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define EMACR_CFG1_SKIPCRC  0
`define EMACR_CFG1_FULLDUP  1
`define EMACR_CFG1_MASK     8'h03
`define EMACR_GAP_RESET     7'h12
`define EMACR_MAXLEN_RESET  16'h0600
`define EMACR_RRPH_MASK     8'h1F
`define EMACR_THRESH_MASK   8'h3F
`define EMACR_INT_MASK      8'h07
`define EMACR_INT_RXDONE    0
`define EMACR_INT_RXERR     1
`define EMACR_INT_FLOW      2
`define EMACR_ST_OK         15
`define EMACR_ST_ALIGN      14
`define EMACR_ST_CRC        13
`define EMACR_HDR_NIBBLES   5'h08
`define EMACR_CRC_INIT      32'hFFFFFFFF
`define EMACR_CRC_RESIDUE   32'hDEBB20E3
`define EMACR_CRC_POLY      32'hEDB88320
`define EMACR_JAM_NIBBLE    4'h5

`endif

/* File: hw/emacr_rx_status_flow.v */
// Purpose: receive status word, register file and buffer flow control
// Assumes: all inputs except nrst synchronous to clk; nibble stream from the line side
// Notes:   one clock, 250 MHz; reads answer one cycle after the strobe
//
// Functional notes
// R1 - status bit 15 is set when a frame arrived complete and clean.
// R2 - status bit 14 is set when a frame held an odd number of nibbles.
// R3 - status bit 13 is set when the received check sequence is wrong.
// R4 - the block keeps working while the processor halts and raises its interrupt.
// R5 - reset restores defaults; unused registers and bits ignore writes and read 0.
// R6 - software writes zero into unused bits.
// R7 - the gap register holds a 7-bit value in bits 6:0 and bit 7 reads 0.
// R8 - the 16-bit frame limit resets to 0600h and may be programmed lower.
// R9 - with header skip set the first 4 bytes stay out of the check sum.
// R10 - the read pointer is high byte over low byte, high bit 0 being bit 8.
// R11 - high pointer bits 7:5 are read-only zero, the lower five are writable.
// R12 - the low six threshold bits set the level and zero disables flow control.
// R13 - in full duplex one pause frame is requested when the level is reached.
// R14 - in half duplex the medium is jammed with nibbles of value 5.
// R15 - jamming stops once free buffers exceed the threshold.
// R16 - flow control fires at count not above the level and re-arms above it.
//
// Implementation choice: strobed register access.
`include "emacr_regs.vh"

module emacr_rx_status_flow (
   input  wire        clk,
   input  wire        nrst,
   // register port
   input  wire [7:0]  regAddr,
   input  wire [7:0]  regWriteData,
   input  wire        regWrite,
   input  wire        regRead,
   output reg  [7:0]  regReadData,
   // line side receive nibbles
   input  wire        rxNibbleValid,
   input  wire [3:0]  rxNibble,
   input  wire        rxFrameEnd,
   input  wire        rxLineError,
   // buffer manager
   input  wire [5:0]  freeRxBufferCount,
   // outputs to the rest of the mac
   output reg  [15:0] rxStatusWord,
   output reg         rxStatusValid,
   output wire [6:0]  nonbackGapValue,
   output wire [15:0] maxFrameLength,
   output wire [15:0] rxReadPointer,
   output reg         pauseRequest,
   output reg         jamActive,
   output wire [3:0]  jamNibble,
   output wire        irq
);

// ----------------------------------------------------------------------
// reset release
// ----------------------------------------------------------------------
reg rstMeta;
reg rstSync;

// release waits two edges so no flop leaves reset half a cycle early
always @(posedge clk or negedge nrst) begin
   if (!nrst) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
   end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
   end
end

wire rstN = rstSync;

// ----------------------------------------------------------------------
// registers
// ----------------------------------------------------------------------
// only the documented bits are stored or, in the 8-bit first configuration register, kept by the write mask, so unused bits cannot read back as ones
reg [7:0]  macConfigOne;
reg [6:0]  nonbackGap;
reg [15:0] maxFrameLen;
reg [7:0]  rxReadPointerLow;
reg [4:0]  rxReadPointerHigh;
reg [5:0]  flowThresholdLevel;
reg [2:0]  intMask;
reg [2:0]  intStatus;

// control bits of the first configuration register
wire skipHeaderCrc = macConfigOne[`EMACR_CFG1_SKIPCRC];
wire fullDuplex    = macConfigOne[`EMACR_CFG1_FULLDUP];

assign nonbackGapValue = nonbackGap;
assign maxFrameLength  = maxFrameLen;
// high byte over low byte, pointer bits 15:13 always zero
assign rxReadPointer   = {3'b000, rxReadPointerHigh, rxReadPointerLow}; // R10 R11

// writes keep only the documented bits; other offsets fall through
always @(posedge clk or negedge rstN) begin
   if (!rstN) begin
      macConfigOne       <= 8'h00; // R5
      nonbackGap         <= `EMACR_GAP_RESET;
      maxFrameLen        <= `EMACR_MAXLEN_RESET; // R8
      rxReadPointerLow   <= 8'h00;
      rxReadPointerHigh  <= 5'h00; // R11
      flowThresholdLevel <= 6'h00;
      intMask            <= 3'h0;
   end else if (regWrite) begin
      case (regAddr)
         `EMACR_OFS_CFG1: begin
            macConfigOne <= regWriteData & `EMACR_CFG1_MASK; // R5
         end
         `EMACR_OFS_GAP: begin
            nonbackGap <= regWriteData[6:0]; // R7
         end
         `EMACR_OFS_MAXLEN_L: begin
            maxFrameLen[7:0] <= regWriteData; // R8
         end
         `EMACR_OFS_MAXLEN_H: begin
            maxFrameLen[15:8] <= regWriteData; // R8
         end
         `EMACR_OFS_RRP_L: begin
            rxReadPointerLow <= regWriteData; // R10
         end
         `EMACR_OFS_RRP_H: begin
            rxReadPointerHigh <= regWriteData[4:0]; // R11
         end
         `EMACR_OFS_THRESH: begin
            flowThresholdLevel <= regWriteData[5:0]; // R12
         end
         `EMACR_OFS_IMASK: begin
            intMask <= regWriteData[2:0];
         end
         default: begin
            // unused offset: write ignored
         end
      endcase
   end
end

// ----------------------------------------------------------------------
// frame checking
// ----------------------------------------------------------------------
// reflected crc-32, one nibble per call, lsb first
function [31:0] crcNibble;
   input [31:0] crcIn;
   input [3:0]  data;
   integer i;
   reg [31:0] c;
   begin
      c = crcIn;
      for (i = 0; i < 4; i = i + 1) begin
         if (c[0] ^ data[i]) begin
            c = (c >> 1) ^ `EMACR_CRC_POLY;
         end else begin
            c = c >> 1;
         end
      end
      crcNibble = c;
   end
endfunction

reg [31:0] crcAcc;
reg [16:0] nibbleCount;
reg        frameLineErr;

// header nibbles are counted but kept out of the check sum
wire inHeader = skipHeaderCrc && (nibbleCount < {12'h000, `EMACR_HDR_NIBBLES});

// accumulate over the frame; the last nibble may come with the end strobe
always @(posedge clk or negedge rstN) begin
   if (!rstN) begin
      crcAcc       <= `EMACR_CRC_INIT;
      nibbleCount  <= 17'h00000;
      frameLineErr <= 1'b0;
   end else if (rxFrameEnd) begin
      crcAcc       <= `EMACR_CRC_INIT;
      nibbleCount  <= 17'h00000;
      frameLineErr <= 1'b0;
   end else begin
      if (rxNibbleValid) begin
         if (!inHeader) begin
            crcAcc <= crcNibble(crcAcc, rxNibble); // R9
         end
         if (nibbleCount != 17'h1FFFF) begin
            nibbleCount <= nibbleCount + 17'h00001;
         end
      end
      if (rxLineError) begin
         frameLineErr <= 1'b1;
      end
   end
end

// fold a nibble that arrives together with the end strobe
reg [31:0] finalCrc;
reg [16:0] finalCount;

always @* begin
   finalCrc   = crcAcc;
   finalCount = nibbleCount;
   if (rxNibbleValid) begin
      if (!inHeader) begin
         finalCrc = crcNibble(crcAcc, rxNibble);
      end
      // hold at the top so a runaway frame never wraps to a short count
      if (nibbleCount != 17'h1FFFF) begin
         finalCount = nibbleCount + 17'h00001;
      end
   end
end

// frame limit compares whole bytes; a trailing odd nibble is not counted
wire oddNibbles = finalCount[0]; // R2
wire crcBad     = finalCrc != `EMACR_CRC_RESIDUE; // R3
wire tooLong    = finalCount[16:1] > maxFrameLen; // R8
wire lineBad    = frameLineErr | rxLineError;
wire frameGood  = !oddNibbles && !crcBad && !tooLong && !lineBad; // R1

// status word of the frame now closing; unused bits stay zero
reg [15:0] next_rxStatusWord;

always @* begin
   next_rxStatusWord                  = 16'h0000;
   next_rxStatusWord[`EMACR_ST_OK]    = frameGood; // R1
   next_rxStatusWord[`EMACR_ST_ALIGN] = oddNibbles; // R2
   next_rxStatusWord[`EMACR_ST_CRC]   = crcBad; // R3
end

// status word holds until the next frame ends
always @(posedge clk or negedge rstN) begin
   if (!rstN) begin
      rxStatusWord  <= 16'h0000;
      rxStatusValid <= 1'b0;
   end else begin
      rxStatusValid <= rxFrameEnd;
      if (rxFrameEnd) begin
         rxStatusWord <= next_rxStatusWord; // R1 R2 R3
      end
   end
end

// ----------------------------------------------------------------------
// flow control
// ----------------------------------------------------------------------
reg  flowArmed;
wire flowEnabled = flowThresholdLevel != 6'h00; // R12
wire atOrBelow   = freeRxBufferCount <= flowThresholdLevel;
wire flowFire    = flowEnabled && flowArmed && atOrBelow; // R16

// one trigger per crossing; the pause request is a single pulse
always @(posedge clk or negedge rstN) begin
   if (!rstN) begin
      pauseRequest <= 1'b0;
   end else begin
      pauseRequest <= flowFire && fullDuplex; // R13
   end
end

// re-arm only once the count climbs above the level again; without this
// a count parked on the level would fire on every edge
always @(posedge clk or negedge rstN) begin
   if (!rstN) begin
      flowArmed <= 1'b1;
   end else if (flowFire) begin
      flowArmed <= 1'b0; // R16
   end else if (!atOrBelow) begin
      flowArmed <= 1'b1; // R16
   end
end

// jam holds until buffers are freed, the feature is switched off or the
// link goes full duplex, where jamming would only corrupt the peer
always @(posedge clk or negedge rstN) begin
   if (!rstN) begin
      jamActive <= 1'b0;
   end else if (flowFire && !fullDuplex) begin
      jamActive <= 1'b1; // R14
   end else if (!atOrBelow || fullDuplex || !flowEnabled) begin
      jamActive <= 1'b0; // R15
   end
end

// jam pattern is a constant; the transmit path muxes it in while jamming
assign jamNibble = jamActive ? `EMACR_JAM_NIBBLE : 4'h0; // R14

// ----------------------------------------------------------------------
// interrupts
// ----------------------------------------------------------------------
wire [2:0] intEvent;
assign intEvent[`EMACR_INT_RXDONE] = rxStatusValid;
assign intEvent[`EMACR_INT_RXERR]  = rxStatusValid && !rxStatusWord[`EMACR_ST_OK];
assign intEvent[`EMACR_INT_FLOW]   = flowFire;

wire statusRead = regRead && (regAddr == `EMACR_OFS_ISTAT);

reg [2:0] next_intStatus;

// a read clears, but an event in the same cycle survives it, so a frame
// ending under the read is never lost
always @* begin
   if (statusRead) begin
      next_intStatus = intEvent;
   end else begin
      next_intStatus = intStatus | intEvent;
   end
end

// sticky status bits
always @(posedge clk or negedge rstN) begin
   if (!rstN) begin
      intStatus <= 3'h0;
   end else begin
      intStatus <= next_intStatus;
   end
end

// no halt gating anywhere, so a halted cpu still gets woken
assign irq = |(intStatus & intMask); // R4

// ----------------------------------------------------------------------
// register read
// ----------------------------------------------------------------------
reg [7:0] next_regReadData;

always @* begin
   next_regReadData = 8'h00;
   case (regAddr)
      `EMACR_OFS_CFG1: begin
         next_regReadData = macConfigOne;
      end
      `EMACR_OFS_GAP: begin
         next_regReadData = {1'b0, nonbackGap}; // R7
      end
      `EMACR_OFS_MAXLEN_L: begin
         next_regReadData = maxFrameLen[7:0];
      end
      `EMACR_OFS_MAXLEN_H: begin
         next_regReadData = maxFrameLen[15:8];
      end
      `EMACR_OFS_RRP_L: begin
         next_regReadData = rxReadPointerLow;
      end
      `EMACR_OFS_RRP_H: begin
         next_regReadData = {3'b000, rxReadPointerHigh}; // R11
      end
      `EMACR_OFS_THRESH: begin
         next_regReadData = {2'b00, flowThresholdLevel};
      end
      `EMACR_OFS_ISTAT: begin
         next_regReadData = {5'h00, intStatus};
      end
      `EMACR_OFS_IMASK: begin
         next_regReadData = {5'h00, intMask};
      end
      `EMACR_OFS_RXST_L: begin
         next_regReadData = rxStatusWord[7:0];
      end
      `EMACR_OFS_RXST_H: begin
         next_regReadData = rxStatusWord[15:8];
      end
      default: begin
         next_regReadData = 8'h00; // R5
      end
   endcase
end

// data stands only in the cycle after the strobe, zero otherwise
always @(posedge clk or negedge rstN) begin
   if (!rstN) begin
      regReadData <= 8'h00;
   end else if (regRead) begin
      regReadData <= next_regReadData;
   end else begin
      regReadData <= 8'h00;
   end
end

endmodule

/* File: sim/emacr_phy_model.sv */
// Purpose: line side model feeding receive nibbles
// Assumes: nibbles change just after a rising edge
// Notes:   idle data starts as the inverse of the last nibble; gaps inside a frame invert it again each cycle
module emacr_phy_model (
   input  wire        clk,
   output logic       rxNibbleValid,
   output logic [3:0] rxNibble,
   output logic       rxFrameEnd,
   output logic       rxLineError
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rxNibbleValid = 1'b0;
      rxNibble = 4'hA;
      rxFrameEnd = 1'b0;
      rxLineError = 1'b0;
   end
   // one nibble per edge, idle gaps emulate a slow line
   task automatic send(input logic [3:0] q[$], input bit bad, input int gap);
      for (int i = 0; i < q.size(); i++) begin
         repeat (gap) begin
            @(posedge clk);
            rxNibbleValid <= 1'b0;
            rxNibble <= ~rxNibble;
         end
         @(posedge clk);
         rxNibbleValid <= 1'b1;
         rxNibble <= q[i];
         rxFrameEnd <= (i == q.size() - 1);
         rxLineError <= bad && (i == q.size() - 1);
      end
      @(posedge clk);
      rxNibbleValid <= 1'b0;
      rxFrameEnd <= 1'b0;
      rxLineError <= 1'b0;
      rxNibble <= ~q[q.size() - 1];
   endtask
endmodule

/* File: sim/emacr_rx_status_flow_sva.sv */
// Purpose: port checks for the receive status and flow block
// Assumes: one clock, nrst active low
// Notes:   bound to every instance of the block
`include "emacr_regs.vh"
module emacr_rx_chk (
   input wire        clk,
   input wire        nrst,
   input wire [7:0]  regAddr,
   input wire        regRead,
   input wire [7:0]  regReadData,
   input wire        rxFrameEnd,
   input wire        rxLineError,
   input wire [15:0] rxStatusWord,
   input wire        rxStatusValid,
   input wire [6:0]  nonbackGapValue,
   input wire [15:0] maxFrameLength,
   input wire [15:0] rxReadPointer,
   input wire [5:0]  freeRxBufferCount,
   input wire        pauseRequest,
   input wire        jamActive,
   input wire [3:0]  jamNibble
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------
   // bus and frame sequences
   // ------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // upper length byte, as seen on a 31h read
   wire [7:0] maxHigh = maxFrameLength[15:8];
   sequence s_rd(a);
      regRead && regAddr == a;
   endsequence
   sequence s_end;
      rxFrameEnd;
   endsequence
   a_read_idle: assert property (!regRead |=> regReadData == 8'h00)
      else $error("read data without a read");
   a_gap_read: assert property (s_rd(`EMACR_OFS_GAP) |=>
      regReadData == {1'b0, $past(nonbackGapValue)}) else $error("gap read wrong");
   a_maxlen_high: assert property (s_rd(`EMACR_OFS_MAXLEN_H) |=>
      regReadData == $past(maxHigh)) else $error("length read wrong");
   a_ptr_top: assert property (rxReadPointer[15:13] == 3'b000)
      else $error("pointer top bits set");
   a_valid_end: assert property (s_end |=> rxStatusValid)
      else $error("no status after frame end");
   a_valid_only: assert property (!rxFrameEnd |=> !rxStatusValid)
      else $error("stray status valid");
   a_status_bits: assert property (rxStatusValid |-> rxStatusWord[12:0] == 13'h0
      && !(rxStatusWord[15] && (rxStatusWord[14] || rxStatusWord[13])))
      else $error("status bits inconsistent");
   a_line_err: assert property (rxFrameEnd && rxLineError |=> !rxStatusWord[15])
      else $error("bad frame marked intact");
   a_pause_once: assert property (pauseRequest ##1 $stable(freeRxBufferCount)[*3]
      |-> !pauseRequest) else $error("pause repeated without rearm");
   a_jam_nibble: assert property (jamNibble == (jamActive ? `EMACR_JAM_NIBBLE : 4'h0))
      else $error("jam nibble wrong");
endmodule

bind emacr_rx_status_flow emacr_rx_chk u_chk (.*);

/* File: sim/tb.sv */
// Purpose: self-checking bench of the receive status and flow block
// Assumes: register reads answer one cycle after the strobe
// Notes:   random data from an xorshift seeded with 21
`include "emacr_regs.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, nrst = 0, regWrite = 0, regRead = 0, maskOn = 0;
   logic [7:0]  regAddr = 0, regWriteData = 0, rdv;
   logic [5:0]  freeRxBufferCount = 6'h3F;
   logic [31:0] seed = 32'd21;
   logic [3:0]  q[$];
   int          error_cnt = 0, n_checks = 0, pauseCnt = 0;
   wire [7:0]   regReadData;
   wire [15:0]  rxStatusWord, maxFrameLength, rxReadPointer;
   wire [6:0]   nonbackGapValue;
   wire [3:0]   rxNibble, jamNibble;
   wire         rxNibbleValid, rxFrameEnd, rxLineError;
   wire         rxStatusValid, pauseRequest, jamActive, irq;
   always #2 clk = ~clk;
   // pause pulses are counted, not sampled, so none slips by
   always @(posedge clk) pauseCnt += pauseRequest;
   emacr_phy_model phy (.clk(clk), .rxNibbleValid(rxNibbleValid), .rxNibble(rxNibble),
      .rxFrameEnd(rxFrameEnd), .rxLineError(rxLineError));
   emacr_rx_status_flow dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
      .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
      .regReadData(regReadData), .rxNibbleValid(rxNibbleValid), .rxNibble(rxNibble),
      .rxFrameEnd(rxFrameEnd), .rxLineError(rxLineError),
      .freeRxBufferCount(freeRxBufferCount), .rxStatusWord(rxStatusWord),
      .rxStatusValid(rxStatusValid), .nonbackGapValue(nonbackGapValue),
      .maxFrameLength(maxFrameLength), .rxReadPointer(rxReadPointer),
      .pauseRequest(pauseRequest), .jamActive(jamActive), .jamNibble(jamNibble), .irq(irq));
   // ------------------------------
   // helpers
   // ------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] crcOf(input logic [3:0] d[$], input int from);
      logic [31:0] c = `EMACR_CRC_INIT;
      for (int i = from; i < d.size(); i++) begin
         c ^= {28'h0, d[i]};
         repeat (4) c = c[0] ? (c >> 1) ^ `EMACR_CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWriteData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 rdv = regReadData;
      chk(rdv, e);
   endtask
   // count moves at one edge; flow reacts at the next edge, the one that samples it
   task automatic cnt(input logic [5:0] v);
      @(posedge clk);
      freeRxBufferCount <= v;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // header skip, odd tail, broken check sum, line error, length limit
   task automatic frame(input int n, input bit skip, odd, badFcs, bad,
                        input logic [15:0] maxLen, input int gap);
      logic [31:0] c;
      logic        o, cb, ok;
      wr(`EMACR_OFS_CFG1, {7'h0, skip});
      q = {};
      for (int i = 0; i < n; i++) q.push_back(4'(rnd()));
      c = ~crcOf(q, skip ? 8 : 0);
      if (badFcs) c[5] = ~c[5];
      for (int i = 0; i < 8; i++) q.push_back(c[4*i +: 4]);
      if (odd) q.push_back(4'h3);
      phy.send(q, bad, gap);
      #1;
      o = q.size() % 2;
      cb = crcOf(q, skip ? 8 : 0) != `EMACR_CRC_RESIDUE;
      ok = !o && !cb && !bad && !(q.size() / 2 > maxLen);
      chk(rxStatusWord, {ok, o, cb, 13'h0});
      chk(rxStatusValid, 1'b1);
      @(posedge clk);
      #1 chk(irq, maskOn);
      rc(`EMACR_OFS_ISTAT, {6'h0, !ok, 1'b1});
      rc(`EMACR_OFS_RXST_H, {ok, o, cb, 5'h0});
      $display("frame of %0d nibbles done", q.size());
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      #200000;
      error_cnt++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rc(`EMACR_OFS_GAP, 8'h12);
      chk(maxFrameLength, 16'h0600);
      rc(`EMACR_OFS_MAXLEN_H, 8'h06);
      wr(`EMACR_OFS_GAP, 8'hFF);
      rc(`EMACR_OFS_GAP, 8'h7F);
      wr(8'h10, 8'h55);
      rc(8'h10, 8'h00);
      wr(`EMACR_OFS_RRP_H, 8'hFF);
      wr(`EMACR_OFS_RRP_L, 8'hA5);
      rc(`EMACR_OFS_RRP_H, 8'h1F);
      chk(rxReadPointer, 16'h1FA5);
      wr(`EMACR_OFS_RXST_L, 8'hFF);
      rc(`EMACR_OFS_RXST_L, 8'h00);
      $display("register test done");
      frame(8, 0, 0, 0, 0, 16'h0600, 0);
      wr(`EMACR_OFS_IMASK, 8'h07);
      maskOn = 1;
      for (int k = 0; k < 12; k++) begin
         frame(8 + 2 * (rnd() % 16), k % 4 == 3, k % 4 == 1, k % 4 == 2,
               k % 6 == 5, `EMACR_MAXLEN_RESET, k % 3);
      end
      wr(`EMACR_OFS_MAXLEN_L, 8'h08);
      wr(`EMACR_OFS_MAXLEN_H, 8'h00);
      frame(8, 0, 0, 0, 0, 16'h0008, 0);
      frame(10, 0, 0, 0, 0, 16'h0008, 1);
      wr(`EMACR_OFS_MAXLEN_H, 8'h06);
      $display("frame test done");
      cnt(6'(10 + rnd() % 50));
      wr(`EMACR_OFS_THRESH, 8'hFF);
      rc(`EMACR_OFS_THRESH, 8'h3F);
      wr(`EMACR_OFS_THRESH, 8'h04);
      wr(`EMACR_OFS_CFG1, 8'h00);
      cnt(4);
      chk(jamActive, 1'b1);
      chk(jamNibble, 4'h5);
      cnt(3);
      chk(jamActive, 1'b1);
      cnt(5);
      chk(jamActive, 1'b0);
      rc(`EMACR_OFS_ISTAT, 8'h04);
      wr(`EMACR_OFS_CFG1, 8'h02);
      pauseCnt = 0;
      cnt(4);
      cnt(2);
      chk(16'(pauseCnt), 16'd1);
      chk(jamActive, 1'b0);
      cnt(5);
      cnt(4);
      chk(16'(pauseCnt), 16'd2);
      wr(`EMACR_OFS_THRESH, 8'h00);
      wr(`EMACR_OFS_CFG1, 8'h00);
      cnt(9);
      cnt(0);
      chk(jamActive, 1'b0);
      chk(16'(pauseCnt), 16'd2);
      $display("flow test done");
      wrap_up();
   end
endmodule
